/* logic/timer0_pkg.sv */
/*
 * Types shared by the timer block: waveform modes, control layout and the
 * captured bus address phase.
 * Assumes nothing beyond a SystemVerilog package compiler.
 */
package timer0_pkg;

	// Order gives the encoding of the two waveform mode bits
	typedef enum logic [1:0] {
		wm_normal,
		wm_phase_pwm,
		wm_ctc,
		wm_fast_pwm
	} wave_mode_e;

	// Control byte layout
	typedef struct packed {
		logic       force_compare_strobe;
		logic       wgm_hi;
		logic [1:0] compare_output_mode_bits;
		logic       wgm_lo;
		logic [2:0] clock_select_bits;
	} ctrl_s;

	// Captured address phase
	typedef struct packed {
		logic       write;
		logic [7:0] addr;
	} ahb_req_s;

	typedef logic [7:0] byte_t;

endpackage

/* logic/timer0_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * 8-bit waveform timer with asynchronous clock option.
 * Assumes a 32-bit AHB-Lite slave with one aligned word per register.
 */
`ifndef TIMER0_REGS_SVH
`define TIMER0_REGS_SVH

// Byte offsets
`define OFS_CONTROL      8'h00
`define OFS_COUNT        8'h04
`define OFS_COMPARE      8'h08
`define OFS_STATUS       8'h0c
`define OFS_EVENT        8'h10
`define OFS_PORT_DIR     8'h14

// Status, event and port direction field positions
`define ST_ASYNC_BIT     3
`define EV_MATCH_BIT     1
`define EV_OVF_BIT       0
`define DIR_OUT_BIT      0

// Reset values
`define RST_BYTE         8'h00

// Counter limits
`define CNT_MAX          8'hff
`define CNT_BOTTOM       8'h00

// Oscillator edges before a temporary register lands
`define ASYNC_LOAD_EDGES 2'd2

// Prescaler masks, divisor minus one
`define DIV8_MASK        10'h007
`define DIV32_MASK       10'h01f
`define DIV64_MASK       10'h03f
`define DIV128_MASK      10'h07f
`define DIV256_MASK      10'h0ff
`define DIV1024_MASK     10'h3ff

`endif

/* logic/timer0_waveform_async_ctrl.sv */
/*
 * Timer block: 8-bit counter, compare unit, waveform output, prescaler,
 * asynchronous oscillator clock option with update-busy handshake, and the
 * AHB-Lite register slave.
 * Assumes a single AHB-Lite master, hclk at 125 MHz, and an oscillator pin
 * much slower than hclk (at least four times slower).
 */
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "timer0_regs.svh"

module timer0_waveform_async_ctrl #(
	parameter int PRESC_W = 10
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        timer_osc_pin,
	output logic             compare_output_pin,
	output logic             compare_output_oe_n,
	output logic             port_override
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	localparam int SLOTS = 3;
	localparam int SL_CTRL = 0;
	localparam int SL_CMP = 1;
	localparam int SL_CNT = 2;

	timer0_pkg::ahb_req_s   req_r;
	logic                   wr_pend_r;
	logic                   rd_pend_r;
	logic                   osc_s1_r;
	logic                   osc_s2_r;
	logic                   osc_s3_r;
	logic                   async_select_r;
	logic                   dir_out_r;
	logic [1:0]             event_r;
	timer0_pkg::ctrl_s      ctrl_r;
	timer0_pkg::byte_t      ctrl_tmp_r;
	timer0_pkg::byte_t      count_r;
	timer0_pkg::byte_t      count_tmp_r;
	timer0_pkg::byte_t      cmp_buf_r;
	timer0_pkg::byte_t      cmp_tmp_r;
	timer0_pkg::byte_t      ocr_r;
	logic                   up_r;
	logic                   block_r;
	logic                   oc_r;
	logic [PRESC_W-1:0]     presc_r;
	logic [SLOTS-1:0]       busy_r;
	logic [1:0]             edge_cnt_r [SLOTS];
	logic [SLOTS-1:0]       slot_load;
	logic [SLOTS-1:0]       slot_write;

	wire logic              accept;
	wire logic              wr_ctrl;
	wire logic              wr_count;
	wire logic              wr_cmp;
	wire logic              wr_status;
	wire logic              wr_event;
	wire logic              wr_dir;
	wire logic              osc_rise;
	wire logic              src_en;
	wire logic              tick;
	wire timer0_pkg::wave_mode_e mode;
	wire logic [1:0]        com;
	wire logic              cnt_max;
	wire logic              cnt_bottom;
	wire logic              match_raw;
	wire logic              match_ignored;
	wire logic              match;
	wire logic              ctrl_load;
	wire logic              count_load;
	wire logic              cmp_load;
	wire timer0_pkg::ctrl_s ctrl_src;
	wire timer0_pkg::byte_t count_src;
	wire timer0_pkg::byte_t cmp_src;
	wire logic              force_now;
	wire logic              ovf_set;
	wire logic              ocr_update;
	wire timer0_pkg::byte_t read_val;
	wire logic [PRESC_W-1:0] presc_mask;

	timer0_pkg::byte_t      count_nxt;
	logic                   up_nxt;
	logic                   oc_nxt;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Register select of the captured address phase
	function automatic logic reg_hit(input timer0_pkg::ahb_req_s r, input logic [7:0] ofs);
		reg_hit = (r.addr == ofs);
	endfunction

	// Prescaler mask for the divided selections
	function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] cs);
		unique case (cs)
			3'h2:    div_mask = PRESC_W'(`DIV8_MASK);
			3'h3:    div_mask = PRESC_W'(`DIV32_MASK);
			3'h4:    div_mask = PRESC_W'(`DIV64_MASK);
			3'h5:    div_mask = PRESC_W'(`DIV128_MASK);
			3'h6:    div_mask = PRESC_W'(`DIV256_MASK);
			3'h7:    div_mask = PRESC_W'(`DIV1024_MASK);
			default: div_mask = '0;
		endcase
	endfunction

	// Compare action of the non-PWM modes and the force strobe
	function automatic logic nonpwm_act(input logic [1:0] c, input logic cur);
		unique case (c)
			2'h1:    nonpwm_act = ~cur;
			2'h2:    nonpwm_act = 1'b0;
			2'h3:    nonpwm_act = 1'b1;
			default: nonpwm_act = cur;
		endcase
	endfunction

	// Level forced by a PWM event; the reserved code leaves the pin alone
	function automatic logic pwm_act(input logic [1:0] c, input logic clr_lvl, input logic cur);
		unique case (c)
			2'h2:    pwm_act = clr_lvl;
			2'h3:    pwm_act = ~clr_lvl;
			default: pwm_act = cur;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Zero-wait writes commit in the data phase; reads take one wait state
	assign accept    = hsel && hready && htrans[1];
	assign wr_ctrl   = wr_pend_r && reg_hit(req_r, `OFS_CONTROL);
	assign wr_count  = wr_pend_r && reg_hit(req_r, `OFS_COUNT);
	assign wr_cmp    = wr_pend_r && reg_hit(req_r, `OFS_COMPARE);
	assign wr_status = wr_pend_r && reg_hit(req_r, `OFS_STATUS);
	assign wr_event  = wr_pend_r && reg_hit(req_r, `OFS_EVENT);
	assign wr_dir    = wr_pend_r && reg_hit(req_r, `OFS_PORT_DIR);

	// Async reads of compare and control show the temporaries
	assign read_val =
		reg_hit(req_r, `OFS_CONTROL) ? (async_select_r ? (ctrl_tmp_r & 8'h7f) : ctrl_r) :
		reg_hit(req_r, `OFS_COUNT)   ? count_r :
		reg_hit(req_r, `OFS_COMPARE) ? (async_select_r ? cmp_tmp_r : cmp_buf_r) :
		reg_hit(req_r, `OFS_STATUS)  ? {4'h0, async_select_r, busy_r[SL_CNT], busy_r[SL_CMP], busy_r[SL_CTRL]} :
		reg_hit(req_r, `OFS_EVENT)   ? {6'h00, event_r} :
		reg_hit(req_r, `OFS_PORT_DIR) ? {7'h00, dir_out_r} :
		8'h00;

	// Address and data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_r     <= '0;
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			wr_pend_r <= accept && hwrite;
			rd_pend_r <= accept && !hwrite;
			if (accept)
				req_r <= '{write: hwrite, addr: {haddr[7:2], 2'b00}};
			if (accept && !hwrite)
				hreadyout <= 1'b0;
			else if (rd_pend_r)
				hreadyout <= 1'b1;
			if (rd_pend_r)
				hrdata <= {24'h00_0000, read_val};
			hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Oscillator pin synchroniser and clock source

	// Two flops before use, a third only for the edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end else begin
			osc_s1_r <= timer_osc_pin;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	// Timer source: every bus clock, or each synchronised oscillator rising edge
	assign osc_rise = osc_s2_r && !osc_s3_r;
	assign src_en   = async_select_r ? osc_rise : 1'b1;

	// Prescaler; a stopped timer holds it cleared
	assign presc_mask = div_mask(ctrl_r.clock_select_bits);
	assign tick = (ctrl_r.clock_select_bits != 3'h0) && src_en &&
		((presc_r & presc_mask) == presc_mask);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			presc_r <= '0;
		else if (ctrl_r.clock_select_bits == 3'h0)
			presc_r <= '0;
		else if (src_en)
			presc_r <= presc_r + PRESC_W'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// Asynchronous write handshake

	// Slot writes: control, compare, counter
	assign slot_write[SL_CTRL] = wr_ctrl && async_select_r;
	assign slot_write[SL_CMP]  = wr_cmp && async_select_r;
	assign slot_write[SL_CNT]  = wr_count && async_select_r;

	// Per-slot edge counter; a fresh write restarts it and wins over the clear
	for (genvar k = 0; k < SLOTS; k++) begin : g_slot
		assign slot_load[k] = busy_r[k] && osc_rise &&
			(edge_cnt_r[k] == `ASYNC_LOAD_EDGES - 2'd1) && !slot_write[k];

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				busy_r[k]     <= 1'b0;
				edge_cnt_r[k] <= 2'd0;
			end else if (slot_write[k]) begin
				busy_r[k]     <= 1'b1;
				edge_cnt_r[k] <= 2'd0;
			end else if (wr_status && (hwdata[`ST_ASYNC_BIT] != async_select_r)) begin
				busy_r[k]     <= 1'b0;
				edge_cnt_r[k] <= 2'd0;
			end else if (slot_load[k]) begin
				busy_r[k]     <= 1'b0;
				edge_cnt_r[k] <= 2'd0;
			end else if (busy_r[k] && osc_rise) begin
				edge_cnt_r[k] <= edge_cnt_r[k] + 2'd1;
			end
		end
	end

	// Destination loads, direct in sync mode, from temporaries in async mode
	assign ctrl_load  = (wr_ctrl && !async_select_r) || slot_load[SL_CTRL];
	assign count_load = (wr_count && !async_select_r) || slot_load[SL_CNT];
	assign cmp_load   = (wr_cmp && !async_select_r) || slot_load[SL_CMP];
	assign ctrl_src   = async_select_r ? ctrl_tmp_r : hwdata[7:0];
	assign count_src  = async_select_r ? count_tmp_r : hwdata[7:0];
	assign cmp_src    = async_select_r ? cmp_tmp_r : hwdata[7:0];

	////////////////////////////////////////////////////////////////////////
	// Compare and waveform decode

	assign mode       = timer0_pkg::wave_mode_e'({ctrl_r.wgm_hi, ctrl_r.wgm_lo});
	assign com        = ctrl_r.compare_output_mode_bits;
	assign cnt_max    = (count_r == `CNT_MAX);
	assign cnt_bottom = (count_r == `CNT_BOTTOM);

	// Continuous compare, masked for one tick after a counter write
	assign match_raw = tick && (count_r == ocr_r) && !block_r;
	assign match_ignored = ((mode == timer0_pkg::wm_fast_pwm) || (mode == timer0_pkg::wm_phase_pwm)) &&
		(ocr_r == `CNT_MAX) && com[1];
	assign match = match_raw && !match_ignored;

	// Force acts only when the new control selects a non-PWM mode
	assign force_now = ctrl_load && ctrl_src.force_compare_strobe && !ctrl_src.wgm_lo;

	// Overflow at BOTTOM in phase PWM, at MAX elsewhere
	assign ovf_set = tick && ((mode == timer0_pkg::wm_phase_pwm) ? (!up_r && cnt_bottom) : cnt_max);

	// Compare buffer to active: immediate in normal and CTC, at TOP in both PWM modes
	assign ocr_update =
		(mode == timer0_pkg::wm_normal) || (mode == timer0_pkg::wm_ctc) ||
		(tick && cnt_max && ((mode == timer0_pkg::wm_fast_pwm) || up_r));

	////////////////////////////////////////////////////////////////////////
	// Counter sequence

	always_comb begin
		count_nxt = count_r;
		up_nxt    = up_r;
		if (count_load) begin
			count_nxt = count_src;
		end else if (tick) begin
			unique case (mode)
				timer0_pkg::wm_normal,
				timer0_pkg::wm_fast_pwm: begin
					count_nxt = count_r + 8'h01;
				end
				timer0_pkg::wm_ctc: begin
					count_nxt = match_raw ? `CNT_BOTTOM : count_r + 8'h01;
				end
				timer0_pkg::wm_phase_pwm: begin
					if (up_r) begin
						up_nxt    = !cnt_max;
						count_nxt = cnt_max ? count_r - 8'h01 : count_r + 8'h01;
					end else begin
						up_nxt    = cnt_bottom;
						count_nxt = cnt_bottom ? count_r + 8'h01 : count_r - 8'h01;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Waveform output level

	always_comb begin
		oc_nxt = oc_r;
		if (force_now) begin
			oc_nxt = nonpwm_act(ctrl_src.compare_output_mode_bits, oc_r);
		end else if (tick) begin
			unique case (mode)
				timer0_pkg::wm_normal,
				timer0_pkg::wm_ctc: begin
					if (match)
						oc_nxt = nonpwm_act(com, oc_r);
				end
				timer0_pkg::wm_fast_pwm: begin
					if (match)
						oc_nxt = pwm_act(com, 1'b0, oc_r);
					else if (cnt_max)
						oc_nxt = pwm_act(com, 1'b1, oc_r);
				end
				timer0_pkg::wm_phase_pwm: begin
					if (match)
						oc_nxt = pwm_act(com, !up_r, oc_r);
					else if (match_ignored && cnt_max && up_r)
						oc_nxt = pwm_act(com, 1'b1, oc_r);
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer state

	// Counter, compare path and output level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= `RST_BYTE;
			up_r    <= 1'b1;
			block_r <= 1'b0;
			oc_r    <= 1'b0;
			ocr_r   <= `RST_BYTE;
		end else begin
			count_r <= count_nxt;
			up_r    <= up_nxt;
			oc_r    <= oc_nxt;
			if (count_load)
				block_r <= 1'b1;
			else if (tick)
				block_r <= 1'b0;
			if (ocr_update)
				ocr_r <= cmp_buf_r;
		end
	end

	// Software side registers; the force bit is never stored in ctrl_r
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r         <= `RST_BYTE;
			ctrl_tmp_r     <= `RST_BYTE;
			count_tmp_r    <= `RST_BYTE;
			cmp_tmp_r      <= `RST_BYTE;
			cmp_buf_r      <= `RST_BYTE;
			async_select_r <= 1'b0;
			dir_out_r      <= 1'b0;
		end else begin
			if (ctrl_load)
				ctrl_r <= {1'b0, ctrl_src[6:0]};
			if (cmp_load)
				cmp_buf_r <= cmp_src;
			if (wr_ctrl)
				ctrl_tmp_r <= hwdata[7:0];
			if (wr_count)
				count_tmp_r <= hwdata[7:0];
			if (wr_cmp)
				cmp_tmp_r <= hwdata[7:0];
			if (wr_status)
				async_select_r <= hwdata[`ST_ASYNC_BIT];
			if (wr_dir)
				dir_out_r <= hwdata[`DIR_OUT_BIT];
		end
	end

	// Sticky event flags, write one to clear; a new event beats the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_r <= 2'b00;
		end else begin
			event_r[`EV_OVF_BIT]   <= (event_r[`EV_OVF_BIT] && !(wr_event && hwdata[`EV_OVF_BIT])) || ovf_set;
			event_r[`EV_MATCH_BIT] <= (event_r[`EV_MATCH_BIT] && !(wr_event && hwdata[`EV_MATCH_BIT])) ||
				match_raw;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin outputs

	// Pin override and driver enable follow the live control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_output_pin  <= 1'b0;
			compare_output_oe_n <= 1'b1;
			port_override       <= 1'b0;
		end else begin
			compare_output_pin  <= oc_nxt;
			port_override       <= (ctrl_r.compare_output_mode_bits != 2'h0);
			compare_output_oe_n <= !((ctrl_r.compare_output_mode_bits != 2'h0) && dir_out_r);
		end
	end

endmodule

/* verification/timer0_monitor.sv */
/* Bus handshake and pin-driver assertions of the timer block.
   Assumes one AHB-Lite master with hready tied to hreadyout. */
`timescale 1ns/1ps
module timer0_monitor #(
	parameter int PRESC_W = 10
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        compare_output_oe_n,
	input wire logic        port_override
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////
	// Address phases taken by the slave
	wire rd_take = hsel && hready && htrans[1] && !hwrite;
	wire wr_take = hsel && hready && htrans[1] && hwrite;
	////////////////////////////////////////
	// Exactly one wait state on reads, none on writes
	read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (wr_take |=> hreadyout)
		else $error("write stalled");
	wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take))
		else $error("wait state without read");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	rdata_upper_a: assert property (hrdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	rdata_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata))
		else $error("read data moved outside read");
	// Driver only when the compare output owns the pin
	drive_override_a: assert property (!compare_output_oe_n |-> port_override)
		else $error("driver on without override");
	override_off_a: assert property (!port_override |-> compare_output_oe_n)
		else $error("driver on while disconnected");
	cover property (rd_take);
	cover property (wr_take);
	cover property (!compare_output_oe_n);
	cover property ($rose(port_override));
endmodule

/* verification/timer0_waveform_async_ctrl_tb.sv */
/* Self-checking bench of the timer block: registers, clock select, force,
   PWM duty and asynchronous updates. Assumes hready looped from hreadyout. */
`timescale 1ns/1ps
module timer0_waveform_async_ctrl_tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        osc;
	logic        pin;
	logic        oe_n;
	logic        ovr;
	logic [31:0] q;
	int          fail_count;
	int          checks_done;

	timer0_waveform_async_ctrl #(.PRESC_W(10)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.timer_osc_pin(osc), .compare_output_pin(pin), .compare_output_oe_n(oe_n),
		.port_override(ovr));
	timer_osc_model #(.HALF_NS(160)) xtal (.osc(osc));

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	////////////////////////////////////////
	// Compare and report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	task automatic wrap_up();
		if (fail_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// One single AHB-Lite transfer; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
		bus(1'b0, a, 8'h00);
		chk(nm, {24'h000000, e}, q);
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		for (int i = 0; i < 5; i++)
			rdchk(8'(i * 4), 8'h00, "reset value");
		bus(1'b1, 8'h18, 8'hff);
		rdchk(8'h18, 8'h00, "unmapped");
		bus(1'b1, 8'h04, 8'h5a);
		rdchk(8'h04, 8'h5a, "count");
		bus(1'b1, 8'h08, 8'ha5);
		rdchk(8'h08, 8'ha5, "compare");
	endtask
	// Ticks over sixteen divided periods, for every divisor
	task automatic t_clksel();
		int dv [7] = '{1, 8, 32, 64, 128, 256, 1024};
		for (int c = 1; c < 8; c++) begin
			bus(1'b1, 8'h04, 8'h00);
			bus(1'b1, 8'h00, 8'(c));
			repeat (16 * dv[c - 1]) @(posedge hclk);
			bus(1'b1, 8'h00, 8'h00);
			bus(1'b0, 8'h04, 8'h00);
			chk("ticks", 32'h1, 32'(q >= 14 && q <= 21));
		end
	endtask
	// Forced compare on a stopped counter: toggle, set, clear, CTC toggle
	task automatic t_force();
		logic [7:0] c [5] = '{8'h90, 8'h90, 8'hb0, 8'ha0, 8'hd0};
		logic       e [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		bus(1'b1, 8'h10, 8'h03);
		bus(1'b1, 8'h14, 8'h01);
		bus(1'b1, 8'h04, 8'h33);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, 8'h00, c[i]);
			repeat (4) @(posedge hclk);
			chk("pin", 32'(e[i]), 32'(pin));
			chk("driver", 32'h0, 32'(oe_n));
		end
		rdchk(8'h04, 8'h33, "count after force");
		rdchk(8'h10, 8'h00, "event after force");
		rdchk(8'h00, 8'h50, "strobe reads zero");
		bus(1'b1, 8'h14, 8'h00);
		repeat (3) @(posedge hclk);
		chk("driver off", 32'h1, 32'(oe_n));
		chk("override", 32'h1, 32'(ovr));
		bus(1'b1, 8'h00, 8'h00);
		repeat (3) @(posedge hclk);
		chk("disconnect", 32'h0, 32'(ovr));
	endtask
	// High cycles of the pin over n cycles, within four of e
	task automatic duty(input logic [7:0] c, input logic [7:0] m, input int n, input int e);
		int hits;
		hits = 0;
		bus(1'b1, 8'h00, 8'h00);
		bus(1'b1, 8'h08, m);
		bus(1'b1, 8'h00, c);
		repeat (600) @(posedge hclk);
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			if (pin === 1'b1)
				hits++;
		end
		chk("high cycles", 32'h1, 32'(hits >= e - 4 && hits <= e + 4));
	endtask
	task automatic t_modes();
		duty(8'h69, 8'h80, 512, 257);
		duty(8'h79, 8'h80, 512, 255);
		duty(8'h69, 8'hff, 512, 512);
		duty(8'h29, 8'h40, 1020, 256);
		duty(8'h39, 8'h40, 1020, 764);
		duty(8'h29, 8'hff, 1020, 1020);
		duty(8'h11, 8'h80, 512, 256);
		duty(8'h51, 8'h10, 340, 170);
		bus(1'b0, 8'h04, 8'h00);
		chk("ctc top", 32'h1, 32'(q <= 16));
		bus(1'b1, 8'h00, 8'h00);
		bus(1'b1, 8'h10, 8'h03);
		bus(1'b1, 8'h04, 8'hf0);
		bus(1'b1, 8'h00, 8'h01);
		repeat (40) @(posedge hclk);
		bus(1'b0, 8'h10, 8'h00);
		chk("overflow", 32'h1, 32'(q[0]));
	endtask
	// Counter write hides the match on the next tick only
	task automatic t_block();
		bus(1'b1, 8'h00, 8'h00);
		bus(1'b1, 8'h10, 8'h03);
		bus(1'b1, 8'h08, 8'h20);
		bus(1'b1, 8'h04, 8'h20);
		bus(1'b1, 8'h00, 8'h01);
		repeat (20) @(posedge hclk);
		bus(1'b1, 8'h00, 8'h00);
		rdchk(8'h10, 8'h00, "blocked match");
		bus(1'b1, 8'h04, 8'h1f);
		bus(1'b1, 8'h00, 8'h01);
		repeat (20) @(posedge hclk);
		bus(1'b1, 8'h00, 8'h00);
		rdchk(8'h10, 8'h02, "match after tick");
	endtask
	////////////////////////////////////////
	task automatic wait_idle();
		for (int i = 0; i < 60; i++) begin
			bus(1'b0, 8'h0c, 8'h00);
			if (q[2:0] === 3'b000)
				break;
		end
		chk("busy clear", 32'h8, q);
	endtask
	task automatic t_async();
		bus(1'b1, 8'h00, 8'h00);
		bus(1'b1, 8'h0c, 8'h08);
		bus(1'b1, 8'h08, 8'h77);
		rdchk(8'h0c, 8'h0a, "compare busy");
		rdchk(8'h08, 8'h77, "compare temp");
		wait_idle();
		bus(1'b1, 8'h04, 8'h00);
		rdchk(8'h0c, 8'h0c, "count busy");
		wait_idle();
		bus(1'b1, 8'h00, 8'h01);
		rdchk(8'h0c, 8'h09, "control busy");
		rdchk(8'h00, 8'h01, "control temp");
		wait_idle();
		repeat (400) @(posedge hclk);
		bus(1'b1, 8'h00, 8'h00);
		wait_idle();
		bus(1'b0, 8'h04, 8'h00);
		chk("osc ticks", 32'h1, 32'(q >= 9 && q <= 15));
	endtask
	////////////////////////////////////////
	initial begin
		repeat (80000) @(posedge hclk);
		fail_count++;
		wrap_up();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_clksel();
		t_force();
		t_modes();
		t_block();
		t_async();
		wrap_up();
	end
endmodule

bind timer0_waveform_async_ctrl timer0_monitor #(.PRESC_W(PRESC_W)) mon (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp), .compare_output_oe_n(compare_output_oe_n),
	.port_override(port_override));

/* verification/timer_osc_model.sv */
/* Crystal source for the timer oscillator pin.
   Assumes the block samples the pin with a bus clock over four times faster. */
`timescale 1ns/1ps
module timer_osc_model #(
	parameter int HALF_NS = 160
) (
	output logic osc
);
	// Free-running crystal, phase unrelated to hclk
	initial begin
		osc = 1'b0;
		#37;
		forever #(HALF_NS) osc = ~osc;
	end
endmodule
